// *** rtl/irq_ctrl_map.vh ***
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH
// register byte addresses (printed index 0xE8 is a word index: address is 4 x index)
`define EVENT_FLAGS_IDX     8'hE8
`define EVENT_FLAGS_ADDR    12'h3A0
`define PRIO_LO_ADDR        12'h000
`define PRIO_HI_ADDR        12'h004
`define IRQ_EN_ADDR         12'h008
`define LINE_FLAGS_ADDR     12'h00C
`define CORE_CTRL_ADDR      12'h010
`define CORE_STAT_ADDR      12'h014
`define ADDR_BITS           12
// event flags register fields
`define EVF_XFER_FLAG       0
`define EVF_SEC_FLAG        1
`define EVF_XFER_EN         2
`define EVF_SEC_EN          3
// enable register fields
`define EN_GLOBAL           7
// core control fields
`define CC_PIN_HI_FALL      0
`define CC_PIN_LO_FALL      1
// reset values
`define PRIO_RESET          8'h00
`define EN_RESET            8'h00
// vectors
`define VEC_EXT0            16'h0003
`define VEC_TMR0            16'h000B
`define VEC_EXT1            16'h0013
`define VEC_TMR1            16'h001B
`define VEC_SER0            16'h0023
`define VEC_SER1            16'h0083
`define VEC_EXT2            16'h004B
`define VEC_EXT3            16'h0053
`define VEC_EXT4            16'h005B
`define VEC_EXT5            16'h0063
`define VEC_EXT6            16'h006B
// acceptance timing in machine cycles
`define DETECT_CYCLES       1
`define CALL_CYCLES         6
`define GROUPS              6
`endif

// *** rtl/edge_catch.v ***
`timescale 1ns/1ps
module edge_catch #(
    parameter FALLING = 1
) (
    input  wire core_clk_i,
    input  wire rst_n_i,
    input  wire level_i,
    output wire edge_o
);
    reg level_q;
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_i;
        end
    end
    assign edge_o = FALLING ? (level_q & ~level_i) : (~level_q & level_i);
endmodule // edge_catch

// *** rtl/prio_pick.v ***
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
module prio_pick (
    input  wire [10:0] req_i,
    input  wire [5:0]  prio_lo_i,
    input  wire [5:0]  prio_hi_i,
    output reg         any_o,
    output reg  [3:0]  idx_o,
    output reg  [1:0]  level_o
);
    // source index: 0 ext0 1 ser1 2 tmr0 3 ext2 4 ext1 5 ext3 6 tmr1 7 ext4 8 ser0 9 ext5 10 ext6
    integer i;
    reg [2:0] grp;
    reg [1:0] lv;
    always @* begin
        any_o   = 1'b0;
        idx_o   = 4'h0;
        level_o = 2'h0;
        grp     = 3'h0;
        lv      = 2'h0;
        // ascending scan, first hit wins among equals
        for (i = 0; i < 11; i = i + 1) begin
            grp = i[3:1];
            lv  = {prio_hi_i[grp], prio_lo_i[grp]};
            if (req_i[i] && (!any_o || lv > level_o)) begin
                any_o   = 1'b1;
                idx_o   = i[3:0];
                level_o = lv;
            end
        end
    end
endmodule // prio_pick

// *** rtl/external_irq_priority_ctrl.v ***
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
module external_irq_priority_ctrl (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        rst_n_i,
    input  wire        emu_reset_i,
    // ahb-lite slave
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    // event sources
    input  wire        pin_hi_event_i,
    input  wire        pin_lo_event_i,
    input  wire        cmp_event_i,
    input  wire        ce_active_i,
    input  wire        eeprom_busy_i,
    input  wire        ce_transfer_done_event_i,
    input  wire        rtc_second_tick_i,
    input  wire        timer0_overflow_flag_i,
    input  wire        timer1_overflow_flag_i,
    input  wire        serial0_rx_tx_flags_i,
    input  wire        serial1_rx_tx_flags_i,
    // core side
    input  wire        machine_cycle_i,
    input  wire        reti_i,
    output reg         irq_call_o,
    output reg  [15:0] irq_vector_o,
    output reg         irq_busy_o
);
    reg  [7:0]  prio_lo_q;
    reg  [7:0]  prio_hi_q;
    reg  [7:0]  en_q;
    reg  [1:0]  pin_pol_q;
    reg         xfer_en_q;
    reg         sec_en_q;
    reg         xfer_flag_q;
    reg         sec_flag_q;
    reg  [6:0]  line_flag_q;
    reg  [6:0]  line_flag_d;
    // ahb address phase capture
    reg         wr_pend_q;
    reg  [11:0] wr_addr_q;
    // acceptance sequencer
    localparam ST_IDLE   = 2'd0;
    localparam ST_DETECT = 2'd1;
    localparam ST_CALL   = 2'd2;
    localparam integer CALL_LAST = `CALL_CYCLES - 1;
    reg  [1:0]  state_q;
    reg  [2:0]  cyc_q;
    reg  [3:0]  pick_q;
    reg  [1:0]  pick_lvl_q;
    // nesting: one active bit per level
    reg  [3:0]  active_q;
    reg  [3:0]  ack_src_q;
    reg         ack_q;
    wire        take = hsel_i & hready_i & htrans_i[1];
    wire [11:0] raddr = haddr_i[11:0];
    wire        wr_xfer_clr = wr_pend_q && wr_addr_q == `EVENT_FLAGS_ADDR && !hwdata_i[`EVF_XFER_FLAG];
    wire        wr_sec_clr  = wr_pend_q && wr_addr_q == `EVENT_FLAGS_ADDR && !hwdata_i[`EVF_SEC_FLAG];
    wire        wr_line     = wr_pend_q && wr_addr_q == `LINE_FLAGS_ADDR;
    // edge detection per line
    wire [6:0]  edge_hit;
    wire        pin_hi_rise;
    wire        pin_hi_fall;
    wire        pin_lo_rise;
    wire        pin_lo_fall;
    wire        shared_level = rtc_second_tick_i | ce_transfer_done_event_i;
    edge_catch #(.FALLING(0)) u_p0r (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(pin_hi_event_i), .edge_o(pin_hi_rise));
    edge_catch #(.FALLING(1)) u_p0f (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(pin_hi_event_i), .edge_o(pin_hi_fall));
    edge_catch #(.FALLING(0)) u_p1r (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(pin_lo_event_i), .edge_o(pin_lo_rise));
    edge_catch #(.FALLING(1)) u_p1f (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(pin_lo_event_i), .edge_o(pin_lo_fall));
    assign edge_hit[0] = pin_pol_q[`CC_PIN_HI_FALL] ? pin_hi_fall : pin_hi_rise;
    assign edge_hit[1] = pin_pol_q[`CC_PIN_LO_FALL] ? pin_lo_fall : pin_lo_rise;
    edge_catch #(.FALLING(1)) u_l2 (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(cmp_event_i), .edge_o(edge_hit[2]));
    edge_catch #(.FALLING(1)) u_l3 (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(ce_active_i), .edge_o(edge_hit[3]));
    edge_catch #(.FALLING(0)) u_l4 (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(cmp_event_i), .edge_o(edge_hit[4]));
    edge_catch #(.FALLING(1)) u_l5 (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(eeprom_busy_i), .edge_o(edge_hit[5]));
    edge_catch #(.FALLING(1)) u_l6 (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(shared_level), .edge_o(edge_hit[6]));
    // sub-source edges set the dedicated flags
    wire        xfer_rise;
    wire        sec_rise;
    edge_catch #(.FALLING(0)) u_xr (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(ce_transfer_done_event_i), .edge_o(xfer_rise));
    edge_catch #(.FALLING(0)) u_sr (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .level_i(rtc_second_tick_i), .edge_o(sec_rise));
    // request vector in polling order
    wire        en_all = en_q[`EN_GLOBAL];
    wire [6:0]  line_req = line_flag_q & en_q[6:0] & {7{en_all}};
    wire [10:0] req = {line_req[6], line_req[5], serial0_rx_tx_flags_i & en_all,
        line_req[4], timer1_overflow_flag_i & en_all, line_req[3], line_req[1],
        line_req[2], timer0_overflow_flag_i & en_all, serial1_rx_tx_flags_i & en_all,
        line_req[0]};
    wire        req_any;
    wire [3:0]  req_idx;
    wire [1:0]  req_lvl;
    prio_pick u_pick (
        .req_i     (req),
        .prio_lo_i (prio_lo_q[5:0]),
        .prio_hi_i (prio_hi_q[5:0]),
        .any_o     (req_any),
        .idx_o     (req_idx),
        .level_o   (req_lvl)
    );
    // highest level now in service
    reg  [2:0]  cur_lvl;
    always @* begin
        cur_lvl = 3'd0;
        if (active_q[0]) cur_lvl = 3'd1;
        if (active_q[1]) cur_lvl = 3'd2;
        if (active_q[2]) cur_lvl = 3'd3;
        if (active_q[3]) cur_lvl = 3'd4;
    end
    wire        may_take = req_any && ({1'b0, req_lvl} + 3'd1 > cur_lvl);
    function [15:0] vec_of;
        input [3:0] idx;
        begin
            case (idx)
                4'd0:    vec_of = `VEC_EXT0;
                4'd1:    vec_of = `VEC_SER1;
                4'd2:    vec_of = `VEC_TMR0;
                4'd3:    vec_of = `VEC_EXT2;
                4'd4:    vec_of = `VEC_EXT1;
                4'd5:    vec_of = `VEC_EXT3;
                4'd6:    vec_of = `VEC_TMR1;
                4'd7:    vec_of = `VEC_EXT4;
                4'd8:    vec_of = `VEC_SER0;
                4'd9:    vec_of = `VEC_EXT5;
                default: vec_of = `VEC_EXT6;
            endcase
        end
    endfunction
    // index back to line number, 7 = not an external line or line 6 (index 10)
    function [2:0] line_of;
        input [3:0] idx;
        begin
            case (idx)
                4'd0:    line_of = 3'd0;
                4'd3:    line_of = 3'd2;
                4'd4:    line_of = 3'd1;
                4'd5:    line_of = 3'd3;
                4'd7:    line_of = 3'd4;
                4'd9:    line_of = 3'd5;
                default: line_of = 3'd7;
            endcase
        end
    endfunction
    always @* begin
        line_flag_d = line_flag_q;
        if (wr_line) begin
            line_flag_d = line_flag_q & hwdata_i[6:0];
        end
        if (ack_q && ack_src_q != 4'd10 && line_of(ack_src_q) != 3'd7) begin
            line_flag_d[line_of(ack_src_q)] = 1'b0;
        end
        // set wins over any clear in the same cycle
        line_flag_d = line_flag_d | edge_hit;
    end
    // register writes and flags
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            prio_lo_q   <= `PRIO_RESET;
            prio_hi_q   <= `PRIO_RESET;
            en_q        <= `EN_RESET;
            pin_pol_q   <= 2'b00;
            xfer_en_q   <= 1'b0;
            sec_en_q    <= 1'b0;
            sec_flag_q  <= 1'b0;
            line_flag_q <= 7'h00;
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 12'h000;
        end else begin
            wr_pend_q   <= take & hwrite_i;
            wr_addr_q   <= haddr_i[11:0];
            line_flag_q <= line_flag_d;
            sec_flag_q  <= sec_rise | (sec_flag_q & ~wr_sec_clr);
            if (wr_pend_q) begin
                case (wr_addr_q)
                    `PRIO_LO_ADDR:     prio_lo_q <= hwdata_i[7:0];
                    `PRIO_HI_ADDR:     prio_hi_q <= {2'b00, hwdata_i[5:0]};
                    `IRQ_EN_ADDR:      en_q <= hwdata_i[7:0];
                    `CORE_CTRL_ADDR:   pin_pol_q <= hwdata_i[1:0];
                    `EVENT_FLAGS_ADDR: begin
                        xfer_en_q <= hwdata_i[`EVF_XFER_EN];
                        sec_en_q  <= hwdata_i[`EVF_SEC_EN];
                    end
                    default: ;
                endcase
            end
        end
    end
    // transfer flag is outside system reset only on emulator reset
    always @(posedge core_clk_i) begin
        if (!rst_n_i && !emu_reset_i) begin
            xfer_flag_q <= 1'b0;
        end else begin
            xfer_flag_q <= xfer_rise | (xfer_flag_q & ~wr_xfer_clr);
        end
    end
    // acceptance: detect one machine cycle, then six for the call
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q      <= ST_IDLE;
            cyc_q        <= 3'd0;
            pick_q       <= 4'd0;
            pick_lvl_q   <= 2'd0;
            active_q     <= 4'h0;
            ack_q        <= 1'b0;
            ack_src_q    <= 4'd0;
            irq_call_o   <= 1'b0;
            irq_vector_o <= 16'h0000;
            irq_busy_o   <= 1'b0;
        end else begin
            ack_q      <= 1'b0;
            irq_call_o <= 1'b0;
            if (reti_i && state_q == ST_IDLE) begin
                // return ends the highest level in service
                if (active_q[3])      active_q[3] <= 1'b0;
                else if (active_q[2]) active_q[2] <= 1'b0;
                else if (active_q[1]) active_q[1] <= 1'b0;
                else                  active_q[0] <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (machine_cycle_i && may_take && !reti_i) begin
                        state_q    <= ST_DETECT;
                        pick_q     <= req_idx;
                        pick_lvl_q <= req_lvl;
                        irq_busy_o <= 1'b1;
                    end
                end
                ST_DETECT: begin
                    if (machine_cycle_i) begin
                        state_q <= ST_CALL;
                        cyc_q   <= 3'd0;
                    end
                end
                ST_CALL: begin
                    if (machine_cycle_i) begin
                        if (cyc_q == CALL_LAST[2:0]) begin
                            state_q              <= ST_IDLE;
                            irq_call_o           <= 1'b1;
                            irq_vector_o         <= vec_of(pick_q);
                            irq_busy_o           <= 1'b0;
                            active_q[pick_lvl_q] <= 1'b1;
                            ack_q                <= 1'b1;
                            ack_src_q            <= pick_q;
                        end else begin
                            cyc_q <= cyc_q + 3'd1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // ahb-lite: zero wait state, always okay
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (take && !hwrite_i) begin
                case (raddr)
                    `PRIO_LO_ADDR:     hrdata_o <= {24'h000000, prio_lo_q};
                    `PRIO_HI_ADDR:     hrdata_o <= {24'h000000, prio_hi_q};
                    `IRQ_EN_ADDR:      hrdata_o <= {24'h000000, en_q};
                    `LINE_FLAGS_ADDR:  hrdata_o <= {25'h0000000, line_flag_q};
                    `CORE_CTRL_ADDR:   hrdata_o <= {30'h00000000, pin_pol_q};
                    `CORE_STAT_ADDR:   hrdata_o <= {24'h000000, active_q, pick_q};
                    `EVENT_FLAGS_ADDR: hrdata_o <= {28'h0000000, sec_en_q, xfer_en_q,
                        sec_flag_q, xfer_flag_q};
                    default:           hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // external_irq_priority_ctrl

// *** tb/irq_ctrl_properties.sv ***
`timescale 1ns/1ps
module irq_ctrl_checker (
    // clock and reset
    input wire        core_clk_i,
    input wire        rst_n_i,
    // bus and core inputs
    input wire        hsel_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire        hready_i,
    input wire        machine_cycle_i,
    input wire        reti_i,
    // outputs watched
    input wire [31:0] hrdata_o,
    input wire        hreadyout_o,
    input wire        hresp_o,
    input wire        irq_call_o,
    input wire [15:0] irq_vector_o,
    input wire        irq_busy_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    ready_always_a: assert property (hreadyout_o) else $error("slave inserted a wait state");
    resp_okay_a: assert property (!hresp_o) else $error("slave answered with error");
    read_data_a: assert property ($changed(hrdata_o) |-> $past(hsel_i && hready_i && htrans_i[1] && !hwrite_i))
        else $error("read data moved without a read");
    call_pulse_a: assert property (irq_call_o |=> !irq_call_o) else $error("call longer than one cycle");
    call_latency_a: assert property ($rose(irq_busy_o) |-> !irq_call_o[*7] ##[0:13] irq_call_o)
        else $error("call latency out of range");
    busy_end_a: assert property ($fell(irq_busy_o) |-> irq_call_o)
        else $error("busy dropped without call");
    take_cond_a: assert property ($rose(irq_busy_o) |-> $past(machine_cycle_i) && !$past(reti_i))
        else $error("request taken off a machine cycle or on return");
    vector_legal_a: assert property (irq_call_o |-> irq_vector_o inside {16'h0003, 16'h000B, 16'h0013,
        16'h001B, 16'h0023, 16'h0083, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B})
        else $error("call to unknown vector");
    vector_hold_a: assert property (!irq_call_o |-> $stable(irq_vector_o))
        else $error("vector moved without call");
endmodule // irq_ctrl_checker

bind external_irq_priority_ctrl irq_ctrl_checker chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .machine_cycle_i(machine_cycle_i), .reti_i(reti_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .irq_call_o(irq_call_o), .irq_vector_o(irq_vector_o), .irq_busy_o(irq_busy_o));

// *** tb/core_model.sv ***
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input  wire  core_clk_i,
    input  wire  rst_n_i,
    // pacing
    input  wire  slow_i,
    // to controller
    output logic machine_cycle_o,
    output logic reti_o
);
    initial begin
        machine_cycle_o = 1'b1;
        reti_o = 1'b0;
    end
    // slow core: one machine cycle every two clocks stretches acceptance
    always @(posedge core_clk_i) begin
        if (!rst_n_i || !slow_i) machine_cycle_o <= 1'b1;
        else machine_cycle_o <= ~machine_cycle_o;
    end
    // return pulsed for one clock, with no check of the flags
    task do_reti();
        @(posedge core_clk_i);
        reti_o <= 1'b1;
        @(posedge core_clk_i);
        reti_o <= 1'b0;
    endtask
endmodule // core_model

// *** tb/test_external_irq_priority_ctrl.sv ***
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
module test_external_irq_priority_ctrl;
    logic        core_clk_i = 1'b0, rst_n_i = 1'b0, emu_reset_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, slow = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic        pin_hi = 1'b0, pin_lo = 1'b0, cmp = 1'b0, ce_act = 1'b0, ee_busy = 1'b0, xfer = 1'b0, tick = 1'b0;
    wire         machine_cycle_i, reti_i, hreadyout_o, hresp_o, irq_call_o, irq_busy_o;
    wire  [31:0] hrdata_o;
    wire  [15:0] irq_vector_o;
    int          bad_count = 0, comparisons = 0;

    always #10 core_clk_i = ~core_clk_i;

    external_irq_priority_ctrl dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .emu_reset_i(emu_reset_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .pin_hi_event_i(pin_hi), .pin_lo_event_i(pin_lo), .cmp_event_i(cmp),
        .ce_active_i(ce_act), .eeprom_busy_i(ee_busy), .ce_transfer_done_event_i(xfer), .rtc_second_tick_i(tick),
        .timer0_overflow_flag_i(1'b0), .timer1_overflow_flag_i(1'b0), .serial0_rx_tx_flags_i(1'b0),
        .serial1_rx_tx_flags_i(1'b0), .machine_cycle_i(machine_cycle_i), .reti_i(reti_i),
        .irq_call_o(irq_call_o), .irq_vector_o(irq_vector_o), .irq_busy_o(irq_busy_o));
    core_model core (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .machine_cycle_o(machine_cycle_i), .reti_o(reti_i));

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task rdchk(input logic [31:0] a, input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask
    task drive(input int s, input logic v);
        case (s)
            0: pin_hi <= v;
            1: pin_lo <= v;
            2: cmp <= v;
            3: ce_act <= v;
            4: ee_busy <= v;
            5: xfer <= v;
            default: tick <= v;
        endcase
    endtask
    task call_exp(input logic [15:0] v, input string m);
        int n;
        n = 0;
        do begin @(posedge core_clk_i); n++; end while (irq_call_o !== 1'b1 && n < 100);
        // a call that never came must not pass on a stale vector
        chk({31'h0, irq_call_o}, 32'h1, "call missing");
        chk({16'h0, irq_vector_o}, {16'h0, v}, m);
    endtask
    task quiet(input int s, input logic v);
        int c;
        c = 0;
        @(posedge core_clk_i);
        drive(s, v);
        repeat (24) begin @(posedge core_clk_i); c += (irq_call_o === 1'b1); end
        chk(c, 0, "unexpected call");
    endtask
    task step(input int s, input logic v, input logic [15:0] vec);
        @(posedge core_clk_i);
        drive(s, v);
        call_exp(vec, "line vector");
        core.do_reti();
        rdchk(`LINE_FLAGS_ADDR, 32'h0, "flag not cleared on entry");
    endtask
    task done(input string s);
        $display("test %s finished, mismatches %0d", s, bad_count);
    endtask

    task t_regs();
        rdchk(`PRIO_LO_ADDR, 32'h0, "prio lo reset");
        rdchk(`IRQ_EN_ADDR, 32'h0, "enable reset");
        bus(1'b1, `EVENT_FLAGS_ADDR, 32'h0);
        rdchk(`EVENT_FLAGS_ADDR, 32'h0, "event flags");
        bus(1'b1, `PRIO_LO_ADDR, 32'h2A);
        rdchk(`PRIO_LO_ADDR, 32'h2A, "prio lo rw");
        rdchk(32'h18, 32'h0, "unmapped read");
        bus(1'b1, `PRIO_LO_ADDR, 32'h0);
        done("regs");
    endtask
    task t_lines();
        bus(1'b1, `IRQ_EN_ADDR, 32'hBF);
        step(0, 1'b1, `VEC_EXT0);
        quiet(0, 1'b0);
        step(1, 1'b1, `VEC_EXT1);
        quiet(1, 1'b0);
        bus(1'b1, `CORE_CTRL_ADDR, 32'h1);
        quiet(0, 1'b1);
        step(0, 1'b0, `VEC_EXT0);
        step(2, 1'b1, `VEC_EXT4);
        step(2, 1'b0, `VEC_EXT2);
        quiet(3, 1'b1);
        step(3, 1'b0, `VEC_EXT3);
        quiet(4, 1'b1);
        step(4, 1'b0, `VEC_EXT5);
        done("lines");
    endtask
    // slow core here: line 6 flags must survive a long acceptance
    task t_line6();
        slow <= 1'b1;
        bus(1'b1, `IRQ_EN_ADDR, 32'hC0);
        quiet(6, 1'b1);
        rdchk(`EVENT_FLAGS_ADDR, 32'h2, "second flag");
        @(posedge core_clk_i);
        drive(6, 1'b0);
        call_exp(`VEC_EXT6, "tick vector");
        rdchk(`LINE_FLAGS_ADDR, 32'h40, "line 6 flag kept");
        rdchk(`EVENT_FLAGS_ADDR, 32'h2, "sub flag kept");
        bus(1'b1, `EVENT_FLAGS_ADDR, 32'h0);
        bus(1'b1, `LINE_FLAGS_ADDR, 32'h0);
        core.do_reti();
        quiet(5, 1'b1);
        quiet(6, 1'b1);
        quiet(5, 1'b0);
        @(posedge core_clk_i);
        drive(6, 1'b0);
        call_exp(`VEC_EXT6, "combined vector");
        rdchk(`EVENT_FLAGS_ADDR, 32'h3, "both sub flags");
        bus(1'b1, `EVENT_FLAGS_ADDR, 32'h0);
        bus(1'b1, `LINE_FLAGS_ADDR, 32'h0);
        core.do_reti();
        slow <= 1'b0;
        done("line6");
    endtask
    task t_enable();
        bus(1'b1, `IRQ_EN_ADDR, 32'h0);
        quiet(3, 1'b1);
        quiet(3, 1'b0);
        rdchk(`LINE_FLAGS_ADDR, 32'h8, "flag without enable");
        bus(1'b1, `IRQ_EN_ADDR, 32'h88);
        call_exp(`VEC_EXT3, "pending taken");
        core.do_reti();
        done("enable");
    endtask
    task pair(input logic [15:0] first, input logic [15:0] second);
        quiet(2, 1'b1);
        quiet(4, 1'b1);
        @(posedge core_clk_i);
        drive(2, 1'b0);
        drive(4, 1'b0);
        call_exp(first, "first of pair");
        quiet(2, 1'b0);
        core.do_reti();
        call_exp(second, "second of pair");
        core.do_reti();
    endtask
    task t_prio();
        bus(1'b1, `IRQ_EN_ADDR, 32'hA4);
        pair(`VEC_EXT2, `VEC_EXT5);
        bus(1'b1, `PRIO_LO_ADDR, 32'h50);
        bus(1'b1, `PRIO_HI_ADDR, 32'h10);
        pair(`VEC_EXT5, `VEC_EXT2);
        bus(1'b1, `LINE_FLAGS_ADDR, 32'h0);
        done("prio");
    endtask
    // resets held four edges so checker history is settled before release
    task t_emu();
        bus(1'b1, `IRQ_EN_ADDR, 32'h0);
        quiet(5, 1'b1);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        emu_reset_i <= 1'b1;
        xfer <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        emu_reset_i <= 1'b0;
        rdchk(`EVENT_FLAGS_ADDR, 32'h1, "flag through emulator reset");
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rdchk(`EVENT_FLAGS_ADDR, 32'h0, "flag after plain reset");
        done("emu");
    endtask

    task end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_lines();
        t_line6();
        t_enable();
        t_prio();
        t_emu();
        end_sim();
    end
    // whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk_i);
        bad_count++;
        end_sim();
    end
endmodule // test_external_irq_priority_ctrl
